/* hw/ppg_timer.sv */
/*
  One base timer channel in programmable pulse generator mode, APB slave.
  Assumes APB3 with zero wait states, inputs synchronous to pclk, and a
  sideband rmw_access that is high during the read of a read-modify-write.
*/
// Our own choices: the APB slave port and the placing of the registers.
// Overview of operation
// - Function select: 000 reset, 001 PWM, 010 PPG, 011 reload, 100 capture.
// - Polarity bit 0 gives LOW idle output, 1 gives HIGH idle output.
// - Mode bit: 0 continuous, 1 one-shot; change only while stopped.
// - Count enable 1 runs the counter; writing 0 stops it.
// - Writing 0 to count enable forces the pulse output LOW.
// - Software trigger bit starts when enabled and always reads 0.
// - Writing enable and trigger together enables and starts at once.
// - Software trigger works whatever the edge selection.
// - Extension byte holds only clock select MSB; other bits read 0.
// - Trigger flag with its enable raises an interrupt request.
// - Underflow flag with its enable raises an interrupt request.
// - Trigger flag sets on any trigger; write 0 clears, 1 keeps.
// - Read-modify-write reads return 1 for both flags.
// - Underflow flag sets at end of HIGH width; write 0 clears.
// - LOW reload loads counter on start and after HIGH underflow.
// - HIGH reload goes to buffer then counter after LOW underflow.
// - Counter readback register shows the down counter, 0 after reset.
// - Each phase lasts reload plus one count clocks.
// - Four-bit clock select: prescaled machine clock or external edges.
// - Edge select: 00 off, 01 rising, 10 falling, 11 both.
// - Restart enable lets triggers restart a running pulse.
`timescale 1ns/1ns
`default_nettype none
module ppg_timer
  import ppg_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rmw_access,
  input wire logic trigger_in,
  input wire logic ext_clock_in,
  output logic pulse_out,
  output logic irq_req
);

  ctrl_t ctrl_q;
  status_t stat_q;
  logic clock_select_msb_q;
  logic [15:0] low_width_reload_q;
  logic [15:0] high_width_reload_q;
  logic [15:0] high_width_buffer_q;
  logic [15:0] count_q;
  phase_t phase_q;
  logic [10:0] prescale_q;
  logic trig_in_q;
  logic ext_clk_q;
  logic force_low_q;
  logic pulse_q;
  logic [31:0] rdata_d;

  // Prescaler limit, divide-by minus one; external and prohibited codes give no tick
  function automatic logic [10:0] div_limit(input logic [3:0] sel);
    logic [10:0] lim;
    lim = PRESCALE_ZERO;
    unique case (sel)
      4'h0: lim = 11'h000;
      4'h1: lim = 11'h003;
      4'h2: lim = 11'h00F;
      4'h3: lim = 11'h07F;
      4'h4: lim = 11'h0FF;
      4'h8: lim = 11'h1FF;
      4'h9: lim = 11'h3FF;
      4'hA: lim = 11'h7FF;
      default: lim = PRESCALE_ZERO;
    endcase
    return lim;
  endfunction : div_limit

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_NONE: hit = 1'b0;
      EDGE_RISE: hit = now & ~prev;
      EDGE_FALL: hit = prev & ~now;
      EDGE_BOTH: hit = now ^ prev;
    endcase
    return hit;
  endfunction : edge_hit

  logic access;
  logic wr;
  logic wr_ctrl;
  logic wr_stat;
  logic mapped;
  logic ppg_sel;
  logic sw_trig;
  logic ext_trig;
  logic start_req;
  logic start;
  logic [3:0] clk_code;
  logic internal_clk;
  logic tick;
  logic at_zero;
  logic low_done;
  logic high_done;
  logic stop_write;

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign wr_ctrl = wr & (paddr == TIMER_CONTROL_OFS);
  assign wr_stat = wr & (paddr == STATUS_CONTROL_OFS);
  assign mapped = (paddr == TIMER_CONTROL_OFS) | (paddr == STATUS_CONTROL_OFS) |
                  (paddr == LOW_WIDTH_RELOAD_OFS) | (paddr == HIGH_WIDTH_RELOAD_OFS) |
                  (paddr == COUNTER_VALUE_OFS);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  assign ppg_sel = ctrl_q.timer_function_select == FUNC_PPG;
  // The trigger bit counts only if the same write leaves the counter enabled
  assign sw_trig = wr_ctrl & pwdata[SW_TRIG_BIT] & pwdata[COUNT_EN_BIT];
  assign ext_trig = ctrl_q.count_enable_bit &
                    edge_hit(ctrl_q.trigger_edge_select, trig_in_q, trigger_in);
  assign start_req = (sw_trig | ext_trig) & ppg_sel;
  assign start = start_req & ((phase_q == PH_IDLE) | ctrl_q.restart_enable);
  assign stop_write = wr_ctrl & ~pwdata[COUNT_EN_BIT];

  assign clk_code = {clock_select_msb_q, ctrl_q.clk_sel};
  assign internal_clk = ~((clk_code == CLK_EXT_RISE) | (clk_code == CLK_EXT_FALL) |
                          (clk_code == CLK_EXT_BOTH));
  always_comb begin
    tick = 1'b0;
    if (internal_clk) begin
      tick = (div_limit(clk_code) != PRESCALE_ZERO || clk_code == 4'h0) &&
             prescale_q == div_limit(clk_code);
    end else begin
      tick = edge_hit(clk_code[1:0] - 2'h0, ext_clk_q, ext_clock_in);
    end
  end
  assign at_zero = count_q == COUNT_ZERO;
  assign low_done = tick & at_zero & (phase_q == PH_LOW) & ~start;
  assign high_done = tick & at_zero & (phase_q == PH_HIGH) & ~start;

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_t'(CTRL_RESET[12:0]);
      clock_select_msb_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.clk_sel <= pwdata[CLK_SEL_LSB +: 3];
        ctrl_q.restart_enable <= pwdata[RESTART_BIT];
        ctrl_q.output_mask <= pwdata[MASK_BIT];
        ctrl_q.trigger_edge_select <= pwdata[EDGE_LSB +: 2];
        ctrl_q.timer_function_select <= pwdata[FUNC_LSB +: 3];
        ctrl_q.output_polarity_select <= pwdata[POLARITY_BIT];
        ctrl_q.oneshot_mode_select <= pwdata[ONESHOT_BIT];
        ctrl_q.count_enable_bit <= pwdata[COUNT_EN_BIT];
      end
      if (wr_stat) begin
        clock_select_msb_q <= pwdata[CLK_MSB_BIT];
      end
    end
  end

  // Flags: a hardware set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q.trigger_irq_flag <= 1'b0;
      stat_q.underflow_irq_flag <= 1'b0;
      stat_q.trigger_irq_enable <= 1'b0;
      stat_q.underflow_irq_enable <= 1'b0;
    end else begin
      if (wr_stat) begin
        stat_q.trigger_irq_enable <= pwdata[TRIG_IE_BIT];
        stat_q.underflow_irq_enable <= pwdata[UDF_IE_BIT];
      end
      if (start_req) begin
        stat_q.trigger_irq_flag <= 1'b1;
      end else if (wr_stat && !pwdata[TRIG_FLAG_BIT]) begin
        stat_q.trigger_irq_flag <= 1'b0;
      end
      if (high_done) begin
        stat_q.underflow_irq_flag <= 1'b1;
      end else if (wr_stat && !pwdata[UDF_FLAG_BIT]) begin
        stat_q.underflow_irq_flag <= 1'b0;
      end
    end
  end

  // Reload registers; reset to zero since software must set them before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_width_reload_q <= RELOAD_RESET;
      high_width_reload_q <= RELOAD_RESET;
    end else begin
      if (wr && paddr == LOW_WIDTH_RELOAD_OFS) begin
        low_width_reload_q <= pwdata[15:0];
      end
      if (wr && paddr == HIGH_WIDTH_RELOAD_OFS) begin
        high_width_reload_q <= pwdata[15:0];
      end
    end
  end

  // Input edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_in_q <= 1'b0;
      ext_clk_q <= 1'b0;
    end else begin
      trig_in_q <= trigger_in;
      ext_clk_q <= ext_clock_in;
    end
  end

  // Prescaler restarts with each start so the first phase is full length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= PRESCALE_ZERO;
    end else if (start || phase_q == PH_IDLE || prescale_q == div_limit(clk_code)) begin
      prescale_q <= PRESCALE_ZERO;
    end else begin
      prescale_q <= prescale_q + 11'h001;
    end
  end

  // Down counter and phase sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_IDLE;
      count_q <= COUNT_RESET;
      high_width_buffer_q <= RELOAD_RESET;
    // The enable bit is still 0 in the cycle of an enable-and-trigger write
    end else if (stop_write || !ppg_sel || (!ctrl_q.count_enable_bit && !start)) begin
      phase_q <= PH_IDLE;
    end else if (start) begin
      phase_q <= PH_LOW;
      count_q <= low_width_reload_q;
      high_width_buffer_q <= high_width_reload_q;
    end else if (low_done) begin
      phase_q <= PH_HIGH;
      count_q <= high_width_buffer_q;
    end else if (high_done) begin
      count_q <= low_width_reload_q;
      high_width_buffer_q <= high_width_reload_q;
      phase_q <= ctrl_q.oneshot_mode_select ? PH_IDLE : PH_LOW;
    end else if (tick && phase_q != PH_IDLE) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // Output pin; a stop write drives LOW whatever the polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_low_q <= 1'b0;
    end else if (stop_write) begin
      force_low_q <= 1'b1;
    end else if (start) begin
      force_low_q <= 1'b0;
    end
  end

  logic pulse_d;
  phase_t phase_next;
  always_comb begin
    phase_next = phase_q;
    if (start) begin
      phase_next = PH_LOW;
    end else if (low_done) begin
      phase_next = PH_HIGH;
    end else if (high_done) begin
      phase_next = ctrl_q.oneshot_mode_select ? PH_IDLE : PH_LOW;
    end
    if (stop_write || (force_low_q && !start)) begin
      pulse_d = 1'b0;
    end else if (ctrl_q.output_mask) begin
      pulse_d = ctrl_q.output_polarity_select;
    end else begin
      pulse_d = (phase_next == PH_HIGH) ^ ctrl_q.output_polarity_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end
  assign pulse_out = pulse_q;

  assign irq_req = (stat_q.trigger_irq_flag & stat_q.trigger_irq_enable) |
                   (stat_q.underflow_irq_flag & stat_q.underflow_irq_enable);

  // Read mux; prdata is registered so it is valid in the access phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      TIMER_CONTROL_OFS: begin
        rdata_d[15:0] = {1'b0, ctrl_q.clk_sel, ctrl_q.restart_enable, ctrl_q.output_mask,
                         ctrl_q.trigger_edge_select, 1'b0, ctrl_q.timer_function_select,
                         ctrl_q.output_polarity_select, ctrl_q.oneshot_mode_select,
                         ctrl_q.count_enable_bit, 1'b0};
      end
      STATUS_CONTROL_OFS: begin
        rdata_d[CLK_MSB_BIT] = clock_select_msb_q;
        rdata_d[TRIG_IE_BIT] = stat_q.trigger_irq_enable;
        rdata_d[UDF_IE_BIT] = stat_q.underflow_irq_enable;
        rdata_d[TRIG_FLAG_BIT] = stat_q.trigger_irq_flag | rmw_access;
        rdata_d[UDF_FLAG_BIT] = stat_q.underflow_irq_flag | rmw_access;
      end
      LOW_WIDTH_RELOAD_OFS: rdata_d[15:0] = low_width_reload_q;
      HIGH_WIDTH_RELOAD_OFS: rdata_d[15:0] = high_width_reload_q;
      COUNTER_VALUE_OFS: rdata_d[15:0] = count_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

  property p_sw_trig_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == TIMER_CONTROL_OFS) |=> !prdata[SW_TRIG_BIT];
  endproperty
  a_sw_trig_reads_zero: assert property (p_sw_trig_reads_zero) else $error("trigger bit read 1");

  property p_stop_forces_low;
    @(posedge pclk) disable iff (!presetn)
      stop_write |=> !pulse_out && phase_q == PH_IDLE;
  endproperty
  a_stop_forces_low: assert property (p_stop_forces_low) else $error("output not low after stop");

  property p_start_loads_low;
    @(posedge pclk) disable iff (!presetn)
      (start && !stop_write) |=>
        count_q == $past(low_width_reload_q) && high_width_buffer_q == $past(high_width_reload_q);
  endproperty
  a_start_loads_low: assert property (p_start_loads_low) else $error("start did not reload");

  property p_low_end_loads_buffer;
    @(posedge pclk) disable iff (!presetn)
      (low_done && ctrl_q.count_enable_bit && ppg_sel && !stop_write) |=>
        phase_q == PH_HIGH && count_q == $past(high_width_buffer_q);
  endproperty
  a_low_end_loads_buffer: assert property (p_low_end_loads_buffer) else $error("bad LOW end");

  property p_trig_flag_sets;
    @(posedge pclk) disable iff (!presetn)
      start_req |=> stat_q.trigger_irq_flag;
  endproperty
  a_trig_flag_sets: assert property (p_trig_flag_sets) else $error("trigger flag not set");

  property p_udf_flag_write_one_keeps;
    @(posedge pclk) disable iff (!presetn)
      (stat_q.underflow_irq_flag && wr_stat && pwdata[UDF_FLAG_BIT]) |=> stat_q.underflow_irq_flag;
  endproperty
  a_udf_flag_write_one_keeps: assert property (p_udf_flag_write_one_keeps) else $error("udf lost");

  property p_irq_follows_flags;
    @(posedge pclk) disable iff (!presetn)
      (stat_q.underflow_irq_flag && stat_q.underflow_irq_enable) |-> irq_req;
  endproperty
  a_irq_follows_flags: assert property (p_irq_follows_flags) else $error("irq missing");

  property p_oneshot_stops;
    @(posedge pclk) disable iff (!presetn)
      (high_done && ctrl_q.oneshot_mode_select && ctrl_q.count_enable_bit && ppg_sel &&
       !stop_write) |=> phase_q == PH_IDLE ##1 (phase_q == PH_IDLE || $past(start));
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops) else $error("one-shot did not stop");

  property p_ext_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == STATUS_CONTROL_OFS) |=> prdata[15:9] == 7'h00;
  endproperty
  a_ext_upper_zero: assert property (p_ext_upper_zero) else $error("reserved bits nonzero");

endmodule : ppg_timer
`default_nettype wire

/* hw/ppg_timer_pkg.sv */
/*
  Shared constants and types of the pulse generator channel: register map,
  field positions, reset values, function, clock and edge codes.
  Assumes a 32-bit APB register bus with byte addresses on paddr.
*/
package ppg_timer_pkg;

  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_CONTROL_OFS = 8'h04;
  localparam logic [7:0] LOW_WIDTH_RELOAD_OFS = 8'h08;
  localparam logic [7:0] HIGH_WIDTH_RELOAD_OFS = 8'h0C;
  localparam logic [7:0] COUNTER_VALUE_OFS = 8'h10;

  // timer_control fields
  localparam int SW_TRIG_BIT = 0;
  localparam int COUNT_EN_BIT = 1;
  localparam int ONESHOT_BIT = 2;
  localparam int POLARITY_BIT = 3;
  localparam int FUNC_LSB = 4;
  localparam int EDGE_LSB = 8;
  localparam int MASK_BIT = 10;
  localparam int RESTART_BIT = 11;
  localparam int CLK_SEL_LSB = 12;
  // status_control fields, timer_control_ext sits in bits 15:8 of the same word
  localparam int UDF_FLAG_BIT = 0;
  localparam int TRIG_FLAG_BIT = 2;
  localparam int UDF_IE_BIT = 4;
  localparam int TRIG_IE_BIT = 6;
  localparam int CLK_MSB_BIT = 8;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  localparam logic [2:0] FUNC_RESET_MODE = 3'h0;
  localparam logic [2:0] FUNC_PWM = 3'h1;
  localparam logic [2:0] FUNC_PPG = 3'h2;
  localparam logic [2:0] FUNC_RELOAD = 3'h3;
  localparam logic [2:0] FUNC_CAPTURE = 3'h4;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [3:0] CLK_EXT_RISE = 4'h5;
  localparam logic [3:0] CLK_EXT_FALL = 4'h6;
  localparam logic [3:0] CLK_EXT_BOTH = 4'h7;
  localparam logic [10:0] PRESCALE_ZERO = 11'h000;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } phase_t;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic restart_enable;
    logic output_mask;
    logic [1:0] trigger_edge_select;
    logic [2:0] timer_function_select;
    logic output_polarity_select;
    logic oneshot_mode_select;
    logic count_enable_bit;
  } ctrl_t;

  typedef struct packed {
    logic trigger_irq_enable;
    logic underflow_irq_enable;
    logic trigger_irq_flag;
    logic underflow_irq_flag;
  } status_t;

endpackage : ppg_timer_pkg

/* verification/ppg_pin_model.sv */
/*
  Pin-side partner of the pulse generator: drives the external trigger pin
  and the external count clock pin.
  Assumes pins are sampled on the rising edge of pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ppg_pin_model (
  input wire logic pclk,
  output logic trigger_in,
  output logic ext_clock_in
);
  // The count clock pin rests low except during a burst of edges
  initial begin
    trigger_in = 1'b0;
    ext_clock_in = 1'b0;
  end

  // Level held several cycles so the synchronous edge detector cannot miss it
  task automatic drive_trigger(input logic level);
    @(posedge pclk);
    trigger_in <= level;
    repeat (4) @(posedge pclk);
  endtask : drive_trigger

  // Each pass gives one rising and one falling count clock edge
  task automatic ext_edges(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      ext_clock_in <= 1'b1;
      @(posedge pclk);
      ext_clock_in <= 1'b0;
    end
  endtask : ext_edges
endmodule : ppg_pin_model
`default_nettype wire

/* verification/base_timer_ppg_mode_tb.sv */
/*
  Self-checking bench of the pulse generator channel over APB.
  Assumes a zero-wait-state slave, flags visible at the status word and
  the pin partner in ppg_pin_model.
*/
`timescale 1ns/1ns
`default_nettype none
module base_timer_ppg_mode_tb
  import ppg_timer_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, rmw_access;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d1, d2;
  logic pready, pslverr, trigger_in, ext_clock_in, pulse_out, irq_req, err, pol;
  logic [15:0] lw, hw;
  int seed = 32'hD71B1031;
  int mismatches = 0;
  int check_count = 0;
  int n;
  int dv;

  ppg_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rmw_access(rmw_access), .trigger_in(trigger_in),
    .ext_clock_in(ext_clock_in), .pulse_out(pulse_out), .irq_req(irq_req));
  ppg_pin_model u_pins (.pclk(pclk), .trigger_in(trigger_in), .ext_clock_in(ext_clock_in));

  always #4 pclk = ~pclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Phase length in pclk cycles for a reload value and a prescale ratio
  function automatic logic [31:0] exp_len(input logic [15:0] v, input int div);
    return (32'(v) + 32'h1) * 32'(div);
  endfunction : exp_len

  // One transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    int w;
    w = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 16);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 16) begin
      mismatches++;
      test_done();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd_chk

  // Waits for the level, then counts the cycles it stands
  task automatic seg(input logic v, output int len);
    int w;
    w = 0;
    len = 0;
    while (pulse_out !== v && w < 200) begin
      @(posedge pclk);
      w++;
    end
    while (pulse_out === v && len < 200) begin
      @(posedge pclk);
      len++;
    end
    if (w >= 200 || len >= 200) begin
      mismatches++;
      test_done();
    end
  endtask : seg

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rmw_access = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pulse_out, 1'b0);
    chk(irq_req, 1'b0);
    chk(pready, 1'b1);
    rd_chk(TIMER_CONTROL_OFS, 32'h0);
    rd_chk(STATUS_CONTROL_OFS, 32'h0);
    rd_chk(COUNTER_VALUE_OFS, 32'h0);
    // Unmapped word: write ignored, reads 0, both answered with an error
    apb(1'b1, 8'h14, 32'hFFFFFFFF, d1, err);
    chk(err, 1'b1);
    apb(1'b0, 8'h14, 32'h0, d1, err);
    chk(d1, 32'h0);
    chk(err, 1'b1);
    wr(TIMER_CONTROL_OFS, 32'h0020);
    // Random widths, both polarities, divide by 1 and 4, software start with edges off
    for (int i = 0; i < 6; i++) begin
      lw = 16'($random(seed) & 7);
      hw = 16'($random(seed) & 7);
      pol = i[0];
      dv = i[1] ? 4 : 1;
      wr(LOW_WIDTH_RELOAD_OFS, {16'h0, lw});
      wr(HIGH_WIDTH_RELOAD_OFS, {16'h0, hw});
      wr(TIMER_CONTROL_OFS, 32'h0023 | (32'(pol) << 3) | (32'(i[1]) << 12));
      rd_chk(TIMER_CONTROL_OFS, 32'h0022 | (32'(pol) << 3) | (32'(i[1]) << 12));
      seg(pol, n);
      seg(~pol, n);
      chk(n, exp_len(hw, dv));
      seg(pol, n);
      chk(n, exp_len(lw, dv));
      seg(~pol, n);
      chk(n, exp_len(hw, dv));
      rd_chk(STATUS_CONTROL_OFS, 32'h05);
      wr(TIMER_CONTROL_OFS, 32'h0020 | (32'(pol) << 3));
      @(posedge pclk);
      chk(pulse_out, 1'b0);
      apb(1'b0, COUNTER_VALUE_OFS, 32'h0, d1, err);
      apb(1'b0, COUNTER_VALUE_OFS, 32'h0, d2, err);
      chk(d2, d1);
      if (i < 5) begin
        wr(STATUS_CONTROL_OFS, 32'h0);
      end
    end
    // Flags: write 1 keeps, write 0 clears, enables gate the request
    chk(irq_req, 1'b0);
    wr(STATUS_CONTROL_OFS, 32'h45);
    chk(irq_req, 1'b1);
    wr(STATUS_CONTROL_OFS, 32'h14);
    chk(irq_req, 1'b0);
    rd_chk(STATUS_CONTROL_OFS, 32'h14);
    rmw_access <= 1'b1;
    rd_chk(STATUS_CONTROL_OFS, 32'h15);
    rmw_access <= 1'b0;
    wr(STATUS_CONTROL_OFS, 32'h0150);
    rd_chk(STATUS_CONTROL_OFS, 32'h0150);
    wr(STATUS_CONTROL_OFS, 32'h0);
    // Pin trigger under each edge selection: rising, falling and both start the one-shot, off does not
    wr(LOW_WIDTH_RELOAD_OFS, 32'h2);
    wr(HIGH_WIDTH_RELOAD_OFS, 32'h3);
    for (int e = 0; e < 4; e++) begin
      wr(TIMER_CONTROL_OFS, 32'h0026 | (32'(e) << 8));
      u_pins.drive_trigger(1'b1);
      rd_chk(STATUS_CONTROL_OFS, (e == 1 || e == 3) ? 32'h4 : 32'h0);
      repeat (20) @(posedge pclk);
      if (e == 1) begin
        chk(pulse_out, 1'b0);
        rd_chk(COUNTER_VALUE_OFS, 32'h2);
        rd_chk(STATUS_CONTROL_OFS, 32'h5);
      end
      wr(STATUS_CONTROL_OFS, 32'h0);
      u_pins.drive_trigger(1'b0);
      rd_chk(STATUS_CONTROL_OFS, (e >= 2) ? 32'h4 : 32'h0);
      wr(TIMER_CONTROL_OFS, 32'h0020);
      wr(STATUS_CONTROL_OFS, 32'h0);
    end
    // External rising-edge count clock: a still pin freezes the count
    wr(TIMER_CONTROL_OFS, 32'h5123);
    rd_chk(COUNTER_VALUE_OFS, 32'h2);
    u_pins.ext_edges(2);
    rd_chk(COUNTER_VALUE_OFS, 32'h0);
    // A pin trigger while running is ignored, then restarts once enabled
    wr(STATUS_CONTROL_OFS, 32'h0);
    u_pins.drive_trigger(1'b1);
    rd_chk(STATUS_CONTROL_OFS, 32'h4);
    rd_chk(COUNTER_VALUE_OFS, 32'h0);
    u_pins.drive_trigger(1'b0);
    wr(TIMER_CONTROL_OFS, 32'h5922);
    u_pins.drive_trigger(1'b1);
    rd_chk(COUNTER_VALUE_OFS, 32'h2);
    wr(TIMER_CONTROL_OFS, 32'h0020);
    test_done();
  end
endmodule : base_timer_ppg_mode_tb
`default_nettype wire
